// >>> logic/rcd_map.vh
// constants for the rgb led command dimmer: bus address, command fields,
// step limits and timing counts.
// assumes a 100 MHz core clock; included by bare name from every design file.
`ifndef RCD_MAP_VH
`define RCD_MAP_VH

// target address and direction bit of the first byte
`define RCD_ADDR          7'h38
`define RCD_RW_WRITE      1'b0
`define RCD_BITS_PER_BYTE 4'h8

// command byte layout: selector on top, operand below
`define RCD_SEL_HI        7
`define RCD_SEL_LO        5
`define RCD_VAL_HI        4
`define RCD_VAL_LO        0

// selector codes
`define RCD_SEL_SHUTDOWN  3'h0
`define RCD_SEL_PEAK      3'h1
`define RCD_SEL_DUTY1     3'h2
`define RCD_SEL_DUTY2     3'h3
`define RCD_SEL_DUTY3     3'h4
`define RCD_SEL_RISE      3'h5
`define RCD_SEL_FALL      3'h6
`define RCD_SEL_RUN       3'h7

// reset value and limits of the 5-bit value registers
`define RCD_RESET_VAL     5'h00
`define RCD_STEP_MAX      5'h1e
`define RCD_DUTY_FULL     5'h1f
`define RCD_TIME_MIN      5'h01

// timing: core clock, millisecond tick, step unit, duty period
`define RCD_CLK_KHZ       100000
`define RCD_TICK_MS       1
`define RCD_TICK_CYC      (`RCD_CLK_KHZ * `RCD_TICK_MS)
`define RCD_STEP_UNIT_MS  8
`define RCD_STEP_UNIT_TICKS (`RCD_STEP_UNIT_MS / `RCD_TICK_MS)
`define RCD_PWM_HZ        2100
`define RCD_PWM_SLOTS     32
`define RCD_PWM_SLOT_CYC  ((`RCD_CLK_KHZ * 1000) / (`RCD_PWM_HZ * `RCD_PWM_SLOTS))

`endif

// >>> logic/rcd_tick.v
// rcd_tick: free divider that pulses tick_out for one cycle every DIV cycles.
// assumes DIV is at least 2 and fits in 17 bits; clr_in restarts the count.
`include "rcd_map.vh"

module rcd_tick
#(
	parameter DIV = 2	// cycles between ticks
)
(
	input  wire mclk_in,
	input  wire rst_n_in,
	input  wire clr_in,
	output reg  tick_out
);

	localparam integer LAST_I = DIV - 1;	// terminal count, full width
	localparam [16:0]  LAST   = LAST_I[16:0];	// terminal count at counter width

	reg [16:0] cnt_r;	// cycles since the last tick

	// count up, wrap at the terminal value and pulse once
	always @(posedge mclk_in)
	begin
		if (!rst_n_in || clr_in)
		begin
			cnt_r    <= 17'h00000;
			tick_out <= 1'b0;
		end
		else if (cnt_r == LAST)
		begin
			cnt_r    <= 17'h00000;
			tick_out <= 1'b1;
		end
		else
		begin
			cnt_r    <= cnt_r + 17'h00001;
			tick_out <= 1'b0;
		end
	end

endmodule

// >>> logic/rcd_pwm.v
// rcd_pwm: one duty channel; compares a shared 32-slot phase with the duty.
// assumes slot_in walks 0..31 at the duty slot rate from the top module.
`include "rcd_map.vh"

module rcd_pwm
(
	input  wire       mclk_in,
	input  wire       rst_n_in,
	input  wire [4:0] slot_in,
	input  wire [4:0] duty_in,
	output reg        on_out
);

	// zero keeps the led dark, full scale keeps it lit through every slot;
	// without the full-scale term slot 31 would blink the led off once a period
	always @(posedge mclk_in)
	begin
		if (!rst_n_in)
			on_out <= 1'b0;
		else
			on_out <= (duty_in == `RCD_DUTY_FULL) || (slot_in < duty_in);
	end

endmodule

// >>> logic/rcd_top.v
// rcd_top: two-wire command receiver, value registers, gradual dimming
// sequencer and three duty generators of the rgb led driver.
// assumes scl/sda arrive raw from pins; sda is open drain, the pad pulls it up.
//
// How it works
// - answer only address 011 1000
// - frame is address byte plus one command
// - bits 7:5 select, bits 4:0 operand
// - selector 000 shuts down, current zero
// - selector 001 loads shared peak step
// - peak step applies directly at acknowledge
// - selectors 010/011/100 load led duties
// - 101 rise target, 110 fall target
// - 111 stores step time, starts dimming
// - duration is step time times steps
// - step walks to target, exponential current
// - a run spans one to thirty-one steps
// - clamp steps, no uncontrolled state
// - each value register has own frame
// - step count is absolute position difference; code gives zero steps if the target is on the wrong side
// - direction follows last target register written
// - duty zero off, full on, 32 slots
// - step zero gives zero current
`include "rcd_map.vh"

module rcd_top
#(
	parameter TICK_CYCLES = `RCD_TICK_CYC	// cycles per millisecond tick
)
(
	input  wire       mclk_in,
	input  wire       rst_n_in,
	input  wire       scl_in,
	input  wire       sda_in,
	output reg        sda_out,
	output reg        sda_oe_n_out,
	output wire       led1_on_out,
	output wire       led2_on_out,
	output wire       led3_on_out,
	output reg  [4:0] current_step_out,
	output reg        dimming_busy_out
);

	// receiver phases
	localparam [1:0] ST_IDLE = 2'b00;	// no frame open
	localparam [1:0] ST_ADDR = 2'b01;	// taking the address byte
	localparam [1:0] ST_CMD  = 2'b10;	// taking the command byte
	localparam [1:0] ST_SKIP = 2'b11;	// not ours or surplus bytes

	// pin synchronisers and filtered levels
	reg  [2:0] scl_sync_r;	// three-stage scl chain
	reg  [2:0] sda_sync_r;	// three-stage sda chain
	reg        scl_lvl_r;	// accepted scl level
	reg        sda_lvl_r;	// accepted sda level
	reg        scl_old_r;	// scl level one cycle back
	reg        sda_old_r;	// sda level one cycle back

	// receiver state
	reg  [1:0] phase_r;	// receiver phase
	reg  [3:0] bit_cnt_r;	// bits taken in this byte
	reg  [7:0] shift_r;	// incoming byte, msb first
	reg        ack_slot_r;	// inside the ninth clock
	reg        cmd_stb_r;	// one-cycle command strobe
	reg  [7:0] cmd_r;	// accepted command byte

	// value registers
	reg  [4:0] peak_current_step_r;	// last peak step written
	reg  [4:0] led1_duty_r;	// duty of led 1
	reg  [4:0] led2_duty_r;	// duty of led 2
	reg  [4:0] led3_duty_r;	// duty of led 3
	reg  [4:0] rise_target_step_r;	// upward end target
	reg  [4:0] fall_target_step_r;	// downward end target
	reg  [4:0] step_time_and_run_r;	// time per step in 8 ms units
	reg        dir_up_r;	// direction of the next run

	// sequencer state
	reg  [4:0] cur_step_r;	// present step position
	reg  [4:0] steps_left_r;	// steps still to walk
	reg  [7:0] ms_cnt_r;	// ms ticks within this step
	reg        run_r;	// dimming in progress
	reg        tick_clr_r;	// restarts the ms divider
	reg  [4:0] pwm_slot_r;	// shared duty phase

	// edge events on the filtered levels
	wire       scl_rise;
	wire       scl_fall;
	wire       start_det;
	wire       stop_det;

	// decoded command fields
	wire [2:0] cmd_sel;
	wire [4:0] cmd_val;

	// run set-up terms
	wire [4:0] tgt_raw;
	wire [4:0] tgt_clamp;
	wire       wrong_way;
	wire [4:0] run_span;
	wire [4:0] time_val;
	wire [31:0] step_ticks_w;
	wire [7:0] step_ticks;
	wire [7:0] ms_cnt_inc;

	// divider outputs and duty channel wiring
	wire       ms_tick;
	wire       slot_tick;
	wire [2:0] led_on;
	wire [14:0] duty_bus;

	// absolute distance between two step positions
	function [4:0] abs_diff;
		input [4:0] a;
		input [4:0] b;
		begin
			if (a > b)
				abs_diff = a - b;
			else
				abs_diff = b - a;
		end
	endfunction

	// raw pins pass three flops; a new level counts once stages two and
	// three agree, which rejects a single-cycle glitch on the slow bus
	always @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			scl_sync_r <= 3'h7;
			sda_sync_r <= 3'h7;
			scl_lvl_r  <= 1'b1;
			sda_lvl_r  <= 1'b1;
			scl_old_r  <= 1'b1;
			sda_old_r  <= 1'b1;
		end
		else
		begin
			scl_sync_r <= {scl_sync_r[1:0], scl_in};
			sda_sync_r <= {sda_sync_r[1:0], sda_in};
			if (scl_sync_r[1] == scl_sync_r[2])
				scl_lvl_r <= scl_sync_r[2];
			if (sda_sync_r[1] == sda_sync_r[2])
				sda_lvl_r <= sda_sync_r[2];
			scl_old_r <= scl_lvl_r;
			sda_old_r <= sda_lvl_r;
		end
	end

	// both lines share the same delay, so start and stop stay ordered
	assign scl_rise  = scl_lvl_r & ~scl_old_r;
	assign scl_fall  = ~scl_lvl_r & scl_old_r;
	assign start_det = scl_lvl_r & scl_old_r & ~sda_lvl_r & sda_old_r;
	assign stop_det  = scl_lvl_r & scl_old_r & sda_lvl_r & ~sda_old_r;

	// byte receiver: samples on scl rise, drives the acknowledge on scl fall
	always @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			phase_r      <= ST_IDLE;
			bit_cnt_r    <= 4'h0;
			shift_r      <= 8'h00;
			ack_slot_r   <= 1'b0;
			cmd_stb_r    <= 1'b0;
			cmd_r        <= 8'h00;
			sda_out      <= 1'b0;
			sda_oe_n_out <= 1'b1;
		end
		else
		begin
			cmd_stb_r <= 1'b0;
			sda_out   <= 1'b0;
			if (start_det)
			// a start, repeated or not, always reopens the address phase
			begin
				phase_r      <= ST_ADDR;
				bit_cnt_r    <= 4'h0;
				ack_slot_r   <= 1'b0;
				sda_oe_n_out <= 1'b1;
			end
			else if (stop_det)
			// stop closes the frame and lets go of the line
			begin
				phase_r      <= ST_IDLE;
				bit_cnt_r    <= 4'h0;
				ack_slot_r   <= 1'b0;
				sda_oe_n_out <= 1'b1;
			end
			else if (scl_rise && phase_r != ST_IDLE && !ack_slot_r)
			// data bit, most significant first
			begin
				shift_r   <= {shift_r[6:0], sda_lvl_r};
				bit_cnt_r <= bit_cnt_r + 4'h1;
			end
			else if (scl_fall && phase_r != ST_IDLE)
			begin
				if (ack_slot_r)
				// end of the ninth clock: release and start the next byte
				begin
					ack_slot_r   <= 1'b0;
					bit_cnt_r    <= 4'h0;
					sda_oe_n_out <= 1'b1;
				end
				else if (bit_cnt_r == `RCD_BITS_PER_BYTE)
				begin
					ack_slot_r <= 1'b1;
					case (phase_r)
						ST_ADDR:
						begin
							// a read address gets no answer: nothing to send back
							if (shift_r[7:1] == `RCD_ADDR && shift_r[0] == `RCD_RW_WRITE)
							begin
								sda_oe_n_out <= 1'b0;
								phase_r      <= ST_CMD;
							end
							else
								phase_r <= ST_SKIP;
						end
						ST_CMD:
						begin
							// acknowledge the command and act on it right now
							sda_oe_n_out <= 1'b0;
							cmd_stb_r    <= 1'b1;
							cmd_r        <= shift_r;
							phase_r      <= ST_SKIP;
						end
						default:
						begin
							// surplus bytes are left unanswered and unused
							sda_oe_n_out <= 1'b1;
						end
					endcase
				end
			end
		end
	end

	// command fields
	assign cmd_sel = cmd_r[`RCD_SEL_HI:`RCD_SEL_LO];
	assign cmd_val = cmd_r[`RCD_VAL_HI:`RCD_VAL_LO];

	// target of the next run, held to the top usable step
	assign tgt_raw   = dir_up_r ? rise_target_step_r : fall_target_step_r;
	assign tgt_clamp = (tgt_raw > `RCD_STEP_MAX) ? `RCD_STEP_MAX : tgt_raw;
	// a target on the wrong side of the present step yields no movement
	assign wrong_way = dir_up_r ? (tgt_clamp < cur_step_r) : (tgt_clamp > cur_step_r);
	assign run_span  = wrong_way ? 5'h00 : abs_diff(cur_step_r, tgt_clamp);
	// a zero step time would make steps vanish; take one unit instead
	assign time_val  = (cmd_val == 5'h00) ? `RCD_TIME_MIN : cmd_val;

	// length of one step in ms ticks; no divider anywhere in the chain
	assign step_ticks_w = step_time_and_run_r * `RCD_STEP_UNIT_TICKS;
	assign step_ticks   = step_ticks_w[7:0];
	assign ms_cnt_inc   = ms_cnt_r + 8'h01;

	// command execution and the dimming sequencer share the step register;
	// a new command always wins over a step falling due in the same cycle
	always @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			peak_current_step_r <= `RCD_RESET_VAL;
			led1_duty_r         <= `RCD_RESET_VAL;
			led2_duty_r         <= `RCD_RESET_VAL;
			led3_duty_r         <= `RCD_RESET_VAL;
			rise_target_step_r  <= `RCD_RESET_VAL;
			fall_target_step_r  <= `RCD_RESET_VAL;
			step_time_and_run_r <= `RCD_RESET_VAL;
			dir_up_r            <= 1'b0;
			cur_step_r          <= `RCD_RESET_VAL;
			steps_left_r        <= 5'h00;
			ms_cnt_r            <= 8'h00;
			run_r               <= 1'b0;
			tick_clr_r          <= 1'b0;
		end
		else
		begin
			tick_clr_r <= 1'b0;
			if (cmd_stb_r)
			begin
				// every value register has its own selector and frame
				case (cmd_sel)
					`RCD_SEL_SHUTDOWN:
					begin
						// operand ignored; step zero means no led current
						cur_step_r <= 5'h00;
						run_r      <= 1'b0;
					end
					`RCD_SEL_PEAK:
					begin
						// shared by all three leds, taken at once
						peak_current_step_r <= cmd_val;
						cur_step_r          <= cmd_val;
						run_r               <= 1'b0;
					end
					`RCD_SEL_DUTY1:
						led1_duty_r <= cmd_val;
					`RCD_SEL_DUTY2:
						led2_duty_r <= cmd_val;
					`RCD_SEL_DUTY3:
						led3_duty_r <= cmd_val;
					`RCD_SEL_RISE:
					begin
						rise_target_step_r <= cmd_val;
						dir_up_r           <= 1'b1;
					end
					`RCD_SEL_FALL:
					begin
						fall_target_step_r <= cmd_val;
						dir_up_r           <= 1'b0;
					end
					default:
					begin
						// store the step time and launch from the present step
						step_time_and_run_r <= time_val;
						steps_left_r        <= run_span;
						run_r               <= (run_span != 5'h00);
						ms_cnt_r            <= 8'h00;
						tick_clr_r          <= 1'b1;
					end
				endcase
			end
			// a tick that left the divider just before its restart would cut
			// the first step short, so the cycle after a launch ignores it
			else if (run_r && ms_tick && !tick_clr_r)
			begin
				if (ms_cnt_inc == step_ticks)
				// one step is due: move one position toward the target
				begin
					ms_cnt_r     <= 8'h00;
					steps_left_r <= steps_left_r - 5'h01;
					if (dir_up_r)
						cur_step_r <= cur_step_r + 5'h01;
					else
						cur_step_r <= cur_step_r - 5'h01;
					if (steps_left_r == 5'h01)
						run_r <= 1'b0;
				end
				else
					ms_cnt_r <= ms_cnt_inc;
			end
		end
	end

	// the analog mirror turns each position into a current; walking the
	// positions evenly therefore gives the exponential brightness curve
	always @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			current_step_out <= 5'h00;
			dimming_busy_out <= 1'b0;
		end
		else
		begin
			current_step_out <= cur_step_r;
			dimming_busy_out <= run_r;
		end
	end

	// shared duty phase: 32 slots make one period near 2.1 kHz
	always @(posedge mclk_in)
	begin
		if (!rst_n_in)
			pwm_slot_r <= 5'h00;
		else if (slot_tick)
			pwm_slot_r <= pwm_slot_r + 5'h01;
	end

	// millisecond tick, restarted at each run so the first step is full
	rcd_tick
	#(
		.DIV(TICK_CYCLES)
	)
	u_ms_tick
	(
		.mclk_in  (mclk_in),
		.rst_n_in (rst_n_in),
		.clr_in   (tick_clr_r),
		.tick_out (ms_tick)
	);

	// duty slot tick
	rcd_tick
	#(
		.DIV(`RCD_PWM_SLOT_CYC)
	)
	u_slot_tick
	(
		.mclk_in  (mclk_in),
		.rst_n_in (rst_n_in),
		.clr_in   (1'b0),
		.tick_out (slot_tick)
	);

	// three identical duty channels
	assign duty_bus = {led3_duty_r, led2_duty_r, led1_duty_r};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : g_led
			rcd_pwm u_pwm
			(
				.mclk_in  (mclk_in),
				.rst_n_in (rst_n_in),
				.slot_in  (pwm_slot_r),
				.duty_in  (duty_bus[gi*5 +: 5]),
				.on_out   (led_on[gi])
			);
		end
	endgenerate

	assign led1_on_out = led_on[0];
	assign led2_on_out = led_on[1];
	assign led3_on_out = led_on[2];

endmodule

// >>> verif/rcd_chk_sva.sv
// rcd_chk: port-level checks on the command dimmer top.
// assumes a bind to rcd_top with its tick parameter handed on.
module rcd_chk
#(
	parameter TICK_CYCLES = 20	// cycles per tick
)
(
	input wire       mclk_in,
	input wire       rst_n_in,
	input wire       scl_in,
	input wire       sda_in,
	input wire       sda_out,
	input wire       sda_oe_n_out,
	input wire       led1_on_out,
	input wire       led2_on_out,
	input wire       led3_on_out,
	input wire [4:0] current_step_out,
	input wire       dimming_busy_out
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int PACE = 8 * TICK_CYCLES;	// shortest step time
	logic [31:0] gap_r;	// cycles since the step last moved
	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);
	// restart on each move and run start, so the first step is timed too
	always @(posedge mclk_in)
	begin
		if (!rst_n_in || $changed(current_step_out) || $rose(dimming_busy_out))
			gap_r <= 32'h0;
		else
			gap_r <= gap_r + 32'h1;
	end
	reset_clear_a: assert property (disable iff (1'b0) !rst_n_in |=>
		current_step_out == 5'h00 && !dimming_busy_out && sda_oe_n_out
		&& !led1_on_out && !led2_on_out && !led3_on_out) else $error("reset state wrong");
	drive_low_a: assert property (sda_out == 1'b0)
		else $error("data drive not low");
	ack_hold_a: assert property ($fell(sda_oe_n_out) |=> !sda_oe_n_out [*6])
		else $error("acknowledge too short");
	ack_release_a: assert property ($fell(sda_oe_n_out) |->
		##[7:80] $rose(sda_oe_n_out)) else $error("acknowledge held too long");
	run_on_ack_a: assert property ($rose(dimming_busy_out) |-> !sda_oe_n_out)
		else $error("run started off acknowledge");
	step_on_ack_a: assert property (!$past(dimming_busy_out) && !dimming_busy_out
		&& $changed(current_step_out) |-> !sda_oe_n_out) else $error("idle step move");
	step_unit_a: assert property (dimming_busy_out && $past(dimming_busy_out)
		&& $changed(current_step_out) |-> current_step_out - $past(current_step_out) == 5'h01
		|| $past(current_step_out) - current_step_out == 5'h01) else $error("step jump");
	step_clamp_a: assert property (dimming_busy_out && $past(dimming_busy_out)
		&& current_step_out > $past(current_step_out) |-> current_step_out <= 5'h1e)
		else $error("step above limit");
	step_pace_a: assert property (dimming_busy_out && $past(dimming_busy_out)
		&& $changed(current_step_out) |-> gap_r >= PACE - 2) else $error("step too early");
	run_end_c: cover property ($fell(dimming_busy_out));
	ack_seen_c: cover property ($fell(sda_oe_n_out));
	top_step_c: cover property (dimming_busy_out && current_step_out == 5'h1e);
endmodule

bind rcd_top rcd_chk #(.TICK_CYCLES(TICK_CYCLES)) u_rcd_chk (.mclk_in(mclk_in),
	.rst_n_in(rst_n_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe_n_out(sda_oe_n_out), .led1_on_out(led1_on_out), .led2_on_out(led2_on_out),
	.led3_on_out(led3_on_out), .current_step_out(current_step_out),
	.dimming_busy_out(dimming_busy_out));

// >>> verif/rcd_ctl_model.sv
// rcd_ctl_model: two-wire bus controller sending write frames.
// assumes a pull-up on data; the clock stands high between frames.
module rcd_ctl_model
(
	input  wire logic dev_oe_n_in,	// device pull-down enable, low = on
	input  wire logic dev_drv_in,	// device drive value
	output logic      scl_out,	// bus clock
	output wire logic sda_out	// data line level
);
	timeunit 1ns;
	timeprecision 100ps;
	logic low_r = 1'b0;	// controller pulls data low
	initial scl_out = 1'b1;
	// open drain: a released line floats up
	assign sda_out = (low_r || (!dev_oe_n_in && !dev_drv_in)) ? 1'b0 : 1'b1;
	// start, n bytes msb first each with an acknowledge slot, stop;
	// the clock stays low for three quarters of the period: a target that
	// hears the bus through pin synchronisers lets go of its acknowledge
	// several core cycles after the fall, and must do so before the rise
	task automatic xfer(input logic [23:0] b, input int n, input int per,
		output logic [2:0] ack);
		int lo;
		int hi;
		lo = per * 3 / 4;
		hi = per - lo;
		ack = 3'h0;
		low_r = 1'b1;
		#(per / 2);
		scl_out = 1'b0;
		for (int i = 0; i < n; i++)
			for (int k = 7; k >= -1; k--)
			begin
				#(lo / 2);
				low_r = k >= 0 && !b[8 * (2 - i) + k];
				#(lo - lo / 2);
				scl_out = 1'b1;
				#(hi * 3 / 4);
				if (k < 0)
					ack[2 - i] = !sda_out;
				#(hi - hi * 3 / 4);
				scl_out = 1'b0;
			end
		#(lo / 2);
		low_r = 1'b1;
		#(lo - lo / 2);
		scl_out = 1'b1;
		#(per / 2);
		low_r = 1'b0;
		#(per / 2);
	endtask
endmodule

// >>> verif/tb.sv
// tb: command frames through the controller model; checks steps,
// run lengths, duty gates and acknowledges. assumes the design in logic/.
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int TICK = 20;	// shortened tick keeps runs brief
	localparam int UNIT = 8 * TICK;	// cycles per step-time unit
	localparam int SLOT = 1488;	// duty slot length
	logic       mclk_in = 1'b0;
	logic       rst_n_in = 1'b0;
	wire        scl, sda, sda_out, sda_oe_n_out, led1, led2, led3, busy;
	wire  [4:0] step;
	logic [4:0] exp_q [$];	// expected step moves, oldest first
	logic [4:0] seen_step = 5'h00;
	int         n_fail = 0, checks = 0, cyc = 0, busy_len = 0;
	rcd_top #(.TICK_CYCLES(TICK)) u_rcd_top (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
		.led1_on_out(led1), .led2_on_out(led2), .led3_on_out(led3),
		.current_step_out(step), .dimming_busy_out(busy));
	rcd_ctl_model u_rcd_ctl_model (.dev_oe_n_in(sda_oe_n_out), .dev_drv_in(sda_out),
		.scl_out(scl), .sda_out(sda));
	always #5 mclk_in = ~mclk_in;
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
		end
	endtask
	// a hang counts as a mismatch
	always @(posedge mclk_in)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			n_fail++;
			$display("wrong value at %0t: run timed out", $time);
			tally_and_finish();
		end
	end
	// every step move takes the oldest note; settled values read at negedge
	always @(negedge mclk_in)
	begin
		if (rst_n_in && step !== seen_step)
			check(step, exp_q.size() ? exp_q.pop_front() : 32'hff, "step move");
		if (busy === 1'b1)
			busy_len++;
		seen_step = step;
	end
	// one frame; acknowledge of the first byte lands in bit 2
	task automatic send(input logic [23:0] b, input int n, input logic [2:0] ea, input int per);
		logic [2:0] got;
		@(posedge mclk_in);
		#1;
		u_rcd_ctl_model.xfer(b, n, per, got);
		check(got, ea, "acknowledge");
	endtask
	task automatic cmd(input logic [2:0] sel, input logic [4:0] val);
		send({8'h70, sel, val, 8'h00}, 2, 3'b110, 80);
	endtask
	// start a run and compare its busy time with steps times step time
	task automatic run(input logic [4:0] t, input int n);
		int e;
		e = n * UNIT * ((t == 5'h00) ? 1 : int'(t));
		busy_len = 0;
		cmd(3'h7, t);
		for (int i = 0; i < 12000 && busy === 1'b1; i++)
			@(negedge mclk_in);
		check(busy_len >= e - 4 && busy_len <= e + 4, 1, "run length");
		$display("test run of %0d steps done", n);
	endtask
	initial
	begin
		logic [4:0] v;
		int         n1, n2, n3;
		void'($urandom(36));
		repeat (3) @(posedge mclk_in);
		#1;
		rst_n_in = 1'b1;
		repeat (5) @(posedge mclk_in);
		#1;
		check({step, busy, led1, led2, led3, sda_oe_n_out}, 10'h001, "reset");
		send({8'h72, 8'h3f, 8'h00}, 2, 3'b000, 80);
		send({8'h71, 8'h3f, 8'h00}, 2, 3'b000, 80);
		v = 5'($urandom_range(29, 1));
		exp_q.push_back(v);
		cmd(3'h1, v);
		exp_q.push_back(5'h1f);
		send({8'h70, 8'h3f, 8'h20}, 3, 3'b110, 240);
		exp_q.push_back(5'h00);
		cmd(3'h0, 5'($urandom_range(31, 1)));
		$display("test direct step done");
		exp_q.push_back(5'h05);
		cmd(3'h1, 5'h05);
		cmd(3'h5, 5'h0f);
		for (int s = 6; s <= 15; s++)
			exp_q.push_back(5'(s));
		run(5'h01, 10);
		cmd(3'h6, 5'h01);
		for (int s = 14; s >= 1; s--)
			exp_q.push_back(5'(s));
		run(5'h02, 14);
		cmd(3'h5, 5'h1f);
		for (int s = 2; s <= 30; s++)
			exp_q.push_back(5'(s));
		run(5'h00, 29);
		cmd(3'h6, 5'h1f);
		run(5'h01, 0);
		v = 5'($urandom_range(30, 1));
		cmd(3'h2, 5'h00);
		cmd(3'h3, 5'h1f);
		cmd(3'h4, v);
		repeat (SLOT + 2) @(negedge mclk_in);
		n1 = 0;
		n2 = 0;
		n3 = 0;
		repeat (32 * SLOT)
		begin
			@(negedge mclk_in);
			n1 += (led1 === 1'b1);
			n2 += (led2 === 1'b1);
			n3 += (led3 === 1'b1);
		end
		check(n1, 0, "led1 on time");
		check(n2, 32 * SLOT, "led2 on time");
		check(n3, v * SLOT, "led3 on time");
		$display("test duty done");
		check(exp_q.size(), 0, "steps left over");
		tally_and_finish();
	end
endmodule
